// ---- bench/eis_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module eis_host_model
(
	input  wire logic       CLK,
	output logic      [7:0] REG_ADDR,
	output logic            REG_RD,
	output logic            REG_WR,
	output logic      [7:0] REG_WDATA,
	input  wire logic [7:0] REG_RDATA,
	output logic      [7:0] GRP0_EVT,
	output logic            LINK_UP,
	output logic      [2:0] EVT
);
	initial
	begin
		REG_ADDR = 8'h00;
		REG_RD = 1'b0;
		REG_WR = 1'b0;
		REG_WDATA = 8'h00;
		GRP0_EVT = 8'h00;
		LINK_UP = 1'b0;
		EVT = 3'h0;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask

	// Released lines show the inverse so a stale value never passes for a live one
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		wt(1);
		REG_ADDR = a;
		REG_RD = 1'b1;
		wt(1);
		REG_RD = 1'b0;
		REG_ADDR = ~a;
		d = REG_RDATA;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		wt(1);
		REG_ADDR = a;
		REG_WDATA = v;
		REG_WR = 1'b1;
		wt(1);
		REG_WR = 1'b0;
		REG_ADDR = ~a;
		REG_WDATA = ~v;
	endtask

	// Both strobes in one cycle: the write must win and no read may happen
	task automatic rw(input logic [7:0] a, input logic [7:0] v);
		wt(1);
		REG_ADDR = a;
		REG_WDATA = v;
		REG_RD = 1'b1;
		REG_WR = 1'b1;
		wt(1);
		REG_RD = 1'b0;
		REG_WR = 1'b0;
		REG_ADDR = ~a;
		REG_WDATA = ~v;
	endtask

	task automatic ev(input logic [7:0] g, input logic [2:0] e);
		wt(1);
		GRP0_EVT = g;
		EVT = e;
		wt(1);
		GRP0_EVT = 8'h00;
		EVT = 3'h0;
	endtask

	task automatic lk(input logic v);
		wt(1);
		LINK_UP = v;
	endtask
endmodule

`default_nettype wire

// ---- bench/ethernet_irq_status_enable_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; $display("ERROR %s exp %h got %h", n, e, g); end end

module ethernet_irq_status_enable_test
	import eis_pkg::*;
();
	logic       clk = 1'b0;
	logic       arst_n = 1'b0;
	logic [7:0] addr, wdata, rdata, grp0, d;
	logic       rd, wr, link, irq;
	logic [2:0] evt;
	logic [7:0] g1e [3] = '{8'h01, 8'h04, 8'h08};
	int         num_errors = 0;
	int         check_count = 0;
	int         cyc = 0;

	always #10 clk = ~clk;

	eis_host_model h (.CLK(clk), .REG_ADDR(addr), .REG_RD(rd), .REG_WR(wr), .REG_WDATA(wdata),
		.REG_RDATA(rdata), .GRP0_EVT(grp0), .LINK_UP(link), .EVT(evt));

	eis_irq_status eis_irq_status_i (.CLK(clk), .ARST_N(arst_n), .REG_ADDR(addr), .REG_RD(rd),
		.REG_WR(wr), .REG_WDATA(wdata), .REG_RDATA(rdata), .GRP0_EVT(grp0), .LINK_UP(link),
		.JABBER_EVT(evt[2]), .AN_FAIL_EVT(evt[1]), .AN_DONE_EVT(evt[0]), .IRQ(irq));

	task automatic results;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
		h.rd(a, d);
		`CHK(n, e, d)
	endtask

	// Whole run needs well under a thousand cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			num_errors++;
			results;
		end
	end

	initial
	begin
		repeat (12) @(posedge clk);
		#1 arst_n = 1'b1;
		rc(EIS_OFS_ENABLE0, 8'h00, "en0 reset");
		rc(EIS_OFS_PEEK1, 8'h00, "peek reset");
		h.wr(EIS_OFS_ENABLE0, 8'hA5);
		rc(EIS_OFS_ENABLE0, 8'hA5, "en0 rw");
		h.wr(EIS_OFS_ENABLE0, 8'h5A);
		rc(EIS_OFS_ENABLE0, 8'h5A, "en0 rw");
		h.wr(EIS_OFS_PEEK1, 8'hFF);
		rc(EIS_OFS_PEEK1, 8'h00, "peek write");
		rc(8'h10, EIS_RDATA_UNMAPPED, "unmapped");
		$display("test registers done");
		h.ev(8'h01, 3'h0);
		h.wt(1);
		`CHK("irq masked", 1'b0, irq)
		h.ev(8'h02, 3'h0);
		h.wt(1);
		`CHK("irq grp0", 1'b1, irq)
		rc(EIS_OFS_STATUS0, 8'h03, "status0");
		h.wt(1);
		`CHK("irq cleared", 1'b0, irq)
		rc(EIS_OFS_STATUS0, 8'h00, "status0 clr");
		h.wr(EIS_OFS_ENABLE0, 8'h03);
		h.ev(8'hFC, 3'h0);
		h.wt(1);
		`CHK("irq en0 gate", 1'b0, irq)
		rc(EIS_OFS_PEEK0, 8'hFC, "peek0");
		rc(EIS_OFS_STATUS0, 8'hFC, "status0 all");
		rc(EIS_OFS_STATUS0, 8'h00, "status0 all clr");
		$display("test group0 done");
		for (int i = 0; i < 3; i++)
		begin
			h.ev(8'h00, 3'h1 << i);
			h.wt(3);
			rc(EIS_OFS_PEEK1, g1e[i], "peek flag");
			rc(EIS_OFS_STATUS1, g1e[i], "cor flag");
			rc(EIS_OFS_STATUS1, 8'h00, "cor cleared");
		end
		h.ev(8'h00, 3'h7);
		h.wr(EIS_OFS_STATUS1, 8'hFF);
		h.rw(EIS_OFS_STATUS1, 8'hFF);
		rc(EIS_OFS_PEEK1, 8'h0D, "peek all");
		rc(EIS_OFS_STATUS1, 8'h0D, "cor all");
		h.lk(1'b1);
		rc(EIS_OFS_PEEK1, 8'h30, "link up");
		rc(EIS_OFS_STATUS1, 8'h30, "link up cor");
		h.lk(1'b0);
		rc(EIS_OFS_PEEK1, 8'h10, "link down");
		rc(EIS_OFS_STATUS1, 8'h10, "link down cor");
		$display("test group1 done");
		h.wr(EIS_OFS_ENABLE1, 8'hFF);
		rc(EIS_OFS_ENABLE1, 8'h3D, "en1 bits");
		h.ev(8'h00, 3'h4);
		h.wt(1);
		`CHK("irq grp1", 1'b1, irq)
		h.wr(EIS_OFS_ENABLE1, 8'h00);
		h.wt(1);
		`CHK("irq gated", 1'b0, irq)
		rc(EIS_OFS_STATUS1, 8'h08, "flag kept");
		$display("test irq done");
		h.ev(8'h01, 3'h4);
		h.wt(1);
		`CHK("irq pre-reset", 1'b1, irq)
		arst_n = 1'b0;
		h.wt(2);
		`CHK("irq in reset", 1'b0, irq)
		arst_n = 1'b1;
		rc(EIS_OFS_ENABLE0, 8'h00, "en0 re-reset");
		rc(EIS_OFS_PEEK1, 8'h00, "peek re-reset");
		rc(EIS_OFS_PEEK0, 8'h00, "peek0 re-reset");
		$display("test reset done");
		results;
	end
endmodule

`default_nettype wire

// ---- verilog/eis_irq_status.sv ----
//Contract
//RQ1: Eight-bit first-group enable, one bit per source, one enables.
//RQ2: First-group enable at 0x64, fully read/write, resets to zero.
//RQ3: Reading second-group clearing status returns flags, then clears them.
//RQ4: Peek copy at 0x7E reads flags without clearing them.
//RQ5: Top two bits of both second-group registers read zero, ignore writes.
//RQ6: Bit 1 of second-group status always reads zero.
//RQ7: Wake flag, bit 5, sets when link comes up; sticky.
//RQ8: Link-change flag, bit 4, sets on any link status change.
//RQ9: Jabber flag, bit 3, sets on jabber detection.
//RQ10: Auto-negotiation failed flag, bit 2, sets on failure.
//RQ11: Auto-negotiation complete flag, bit 0, sets on completion.
//RQ12: Second-group flags stay set until the group is next cleared.
//RQ13: Peek shows same flags, same positions, current state.
//RQ14: First-group enables gate first-group flags; status read clears them.
//RQ15: Second-group flags gated by separate enable register at 0x7D.
//RQ16: Interrupt asserted while any set flag is enabled.
`timescale 1ns/1ps
`default_nettype none

module eis_irq_status
	import eis_pkg::*;
(
	input  wire logic       CLK,
	input  wire logic       ARST_N,
	input  wire logic [7:0] REG_ADDR,
	input  wire logic       REG_RD,
	input  wire logic       REG_WR,
	input  wire logic [7:0] REG_WDATA,
	output logic      [7:0] REG_RDATA,
	input  wire logic [7:0] GRP0_EVT,
	input  wire logic       LINK_UP,
	input  wire logic       JABBER_EVT,
	input  wire logic       AN_FAIL_EVT,
	input  wire logic       AN_DONE_EVT,
	output logic            IRQ
);

	logic [7:0]  en0_q;
	logic [7:0]  en1_q;
	logic [7:0]  flags0_q;
	logic [7:0]  flags0_d;
	logic [7:0]  flags1_q;
	logic [7:0]  flags1_d;
	logic [7:0]  evt1;
	logic        link_prev_q;
	logic [7:0]  rdata_q;
	logic [7:0]  rdata_d;
	logic        irq_q;
	eis_acc_type acc;

	assign acc = REG_WR ? EIS_ACC_WRITE : (REG_RD ? EIS_ACC_READ : EIS_ACC_NONE);

	// Link level history gives the connect and change events
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			link_prev_q <= 1'b0;
		else
			link_prev_q <= LINK_UP;
	end

	always_comb
	begin
		evt1                  = 8'h00;
		evt1[EIS_BIT_WAKE]    = LINK_UP & ~link_prev_q;   // [RQ7]
		evt1[EIS_BIT_LINK]    = LINK_UP ^ link_prev_q;    // [RQ8]
		evt1[EIS_BIT_JABBER]  = JABBER_EVT;               // [RQ9]
		evt1[EIS_BIT_AN_FAIL] = AN_FAIL_EVT;              // [RQ10]
		evt1[EIS_BIT_AN_DONE] = AN_DONE_EVT;              // [RQ11]
	end

	// Enables; writes to other offsets leave them alone
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			en0_q <= EIS_RST_ENABLE0;                    // [RQ2]
		else if (acc == EIS_ACC_WRITE && REG_ADDR == EIS_OFS_ENABLE0)
			en0_q <= REG_WDATA;                          // [RQ1]
	end

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			en1_q <= EIS_RST_ENABLE1;
		else if (acc == EIS_ACC_WRITE && REG_ADDR == EIS_OFS_ENABLE1)
			en1_q <= REG_WDATA & EIS_GRP1_MASK;          // [RQ15]
	end

	// A new event in the clearing cycle survives: set beats clear
	always_comb
	begin
		flags0_d = flags0_q | GRP0_EVT;
		if (acc == EIS_ACC_READ && REG_ADDR == EIS_OFS_STATUS0)
			flags0_d = GRP0_EVT;                         // [RQ14]
	end

	always_comb
	begin
		flags1_d = (flags1_q | evt1) & EIS_GRP1_MASK;    // [RQ12] [RQ6]
		if (acc == EIS_ACC_READ && REG_ADDR == EIS_OFS_STATUS1)
			flags1_d = evt1 & EIS_GRP1_MASK;             // [RQ3]
	end

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			flags0_q <= EIS_RST_STATUS;
		else
			flags0_q <= flags0_d;
	end

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			flags1_q <= EIS_RST_STATUS;
		else
			flags1_q <= flags1_d;
	end

	// Read data is the value before any clear takes effect
	always_comb
	begin
		rdata_d = EIS_RDATA_UNMAPPED;
		case (REG_ADDR)
			EIS_OFS_STATUS0: rdata_d = flags0_q;
			EIS_OFS_PEEK0:   rdata_d = flags0_q;
			EIS_OFS_ENABLE0: rdata_d = en0_q;            // [RQ2]
			EIS_OFS_ENABLE1: rdata_d = en1_q;
			EIS_OFS_STATUS1: rdata_d = flags1_q & EIS_GRP1_MASK;  // [RQ3] [RQ5]
			EIS_OFS_PEEK1:   rdata_d = flags1_q & EIS_GRP1_MASK;  // [RQ4] [RQ13]
			default:         rdata_d = EIS_RDATA_UNMAPPED;
		endcase
	end

	// Data holds between reads so a slow host may sample late
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			rdata_q <= EIS_RDATA_UNMAPPED;
		else if (acc == EIS_ACC_READ)
			rdata_q <= rdata_d;
	end

	// Registered so the pin never glitches on decode hazards
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			irq_q <= 1'b0;
		else
			irq_q <= |(flags0_q & en0_q) | |(flags1_q & en1_q);  // [RQ16] [RQ14] [RQ15]
	end

	assign REG_RDATA = rdata_q;
	assign IRQ       = irq_q;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!ARST_N);

	a_en0_write: // [RQ1]
	assert property (acc == EIS_ACC_WRITE && REG_ADDR == EIS_OFS_ENABLE0
		|=> en0_q == $past(REG_WDATA))
	else $error("enable0 write not stored");

	a_en0_readback: // [RQ2]
	assert property (acc == EIS_ACC_READ && REG_ADDR == EIS_OFS_ENABLE0
		|=> REG_RDATA == $past(en0_q))
	else $error("enable0 readback wrong");

	a_grp1_clear: // [RQ3]
	assert property (acc == EIS_ACC_READ && REG_ADDR == EIS_OFS_STATUS1 && evt1 == 8'h00
		|=> flags1_q == 8'h00 && REG_RDATA == ($past(flags1_q) & EIS_GRP1_MASK))
	else $error("group1 clear on read failed");

	a_peek_keeps: // [RQ4]
	assert property (acc == EIS_ACC_READ && REG_ADDR == EIS_OFS_PEEK1
		|=> (flags1_q & $past(flags1_q)) == $past(flags1_q))
	else $error("peek read altered flags");

	a_top_bits_zero: // [RQ5]
	assert property ($past(acc == EIS_ACC_READ) && ($past(REG_ADDR) == EIS_OFS_STATUS1
		|| $past(REG_ADDR) == EIS_OFS_PEEK1) |-> REG_RDATA[7:6] == 2'b00)
	else $error("unused group1 bits read nonzero");

	a_bit1_zero: // [RQ6]
	assert property (flags1_q[1] == 1'b0 && en1_q[1] == 1'b0)
	else $error("reserved bit 1 set");

	a_wake_set: // [RQ7]
	assert property (LINK_UP && !link_prev_q |=> flags1_q[EIS_BIT_WAKE])
	else $error("wake flag not set on connect");

	a_link_set: // [RQ8]
	assert property ($changed(LINK_UP) && $past(ARST_N) |=> flags1_q[EIS_BIT_LINK])
	else $error("link change flag not set");

	a_jabber_set: // [RQ9]
	assert property (JABBER_EVT |=> flags1_q[EIS_BIT_JABBER])
	else $error("jabber flag not set");

	a_anfail_set: // [RQ10]
	assert property (AN_FAIL_EVT |=> flags1_q[EIS_BIT_AN_FAIL])
	else $error("autoneg fail flag not set");

	a_andone_set: // [RQ11]
	assert property (AN_DONE_EVT |=> flags1_q[EIS_BIT_AN_DONE])
	else $error("autoneg done flag not set");

	a_flags_sticky: // [RQ12]
	assert property (!(acc == EIS_ACC_READ && REG_ADDR == EIS_OFS_STATUS1)
		|=> (flags1_q & $past(flags1_q)) == $past(flags1_q))
	else $error("group1 flag dropped without clear");

	a_peek_matches: // [RQ13]
	assert property (acc == EIS_ACC_READ && REG_ADDR == EIS_OFS_PEEK1
		|=> REG_RDATA == $past(flags1_q))
	else $error("peek differs from flags");

	a_grp0_clear: // [RQ14]
	assert property (acc == EIS_ACC_READ && REG_ADDR == EIS_OFS_STATUS0 && GRP0_EVT == 8'h00
		|=> flags0_q == 8'h00)
	else $error("group0 clear on read failed");

	a_en1_gate: // [RQ15]
	assert property (en1_q == 8'h00 && en0_q == 8'h00 ##1 en1_q == 8'h00 && en0_q == 8'h00
		|-> !IRQ)
	else $error("interrupt with all enables off");

	a_irq_level: // [RQ16]
	assert property (##1 IRQ == $past(|(flags0_q & en0_q) | |(flags1_q & en1_q)))
	else $error("interrupt output mismatch");

	// Group0 flags: set, hold and read back on the host port
	a_grp0_set: // [RQ14]
	assert property (GRP0_EVT != 8'h00
		|=> (flags0_q & $past(GRP0_EVT)) == $past(GRP0_EVT))
	else $error("group0 event lost");

	a_grp0_sticky: // [RQ14]
	assert property (!(acc == EIS_ACC_READ && REG_ADDR == EIS_OFS_STATUS0)
		|=> (flags0_q & $past(flags0_q)) == $past(flags0_q))
	else $error("group0 flag dropped without clear");

	a_grp0_readback: // [RQ14]
	assert property (acc == EIS_ACC_READ && REG_ADDR == EIS_OFS_STATUS0
		|=> REG_RDATA == $past(flags0_q))
	else $error("group0 status read wrong");

	a_peek0_keeps: // [RQ14]
	assert property (acc == EIS_ACC_READ && REG_ADDR == EIS_OFS_PEEK0
		|=> REG_RDATA == $past(flags0_q) && (flags0_q & $past(flags0_q)) == $past(flags0_q))
	else $error("group0 peek wrong or clearing");

	// Enables, unused bits and no spurious group1 flags
	a_en0_hold: // [RQ1]
	assert property (!(acc == EIS_ACC_WRITE && REG_ADDR == EIS_OFS_ENABLE0)
		|=> $stable(en0_q))
	else $error("enable0 changed without write");

	a_en1_write: // [RQ15]
	assert property (acc == EIS_ACC_WRITE && REG_ADDR == EIS_OFS_ENABLE1
		|=> en1_q == ($past(REG_WDATA) & EIS_GRP1_MASK))
	else $error("enable1 write not stored");

	a_en1_unused: // [RQ15]
	assert property (en1_q[7:6] == 2'b00)
	else $error("enable1 unused bits set");

	a_grp1_unused: // [RQ5]
	assert property (flags1_q[7:6] == 2'b00)
	else $error("group1 unused bits set");

	a_bit1_rdata: // [RQ6]
	assert property ($past(acc == EIS_ACC_READ) && ($past(REG_ADDR) == EIS_OFS_STATUS1
		|| $past(REG_ADDR) == EIS_OFS_PEEK1) |-> REG_RDATA[1] == 1'b0)
	else $error("reserved bit 1 read nonzero");

	a_grp1_no_spurious: // [RQ12]
	assert property (evt1 == 8'h00 |=> (flags1_q & ~$past(flags1_q)) == 8'h00)
	else $error("group1 flag set without event");

	// Read data and strobe priority
	a_rdata_hold: // [RQ3]
	assert property (acc != EIS_ACC_READ |=> $stable(REG_RDATA))
	else $error("read data changed without read");

	a_both_no_clear: // [RQ3]
	assert property (REG_RD && REG_WR && REG_ADDR == EIS_OFS_STATUS1
		|=> (flags1_q & $past(flags1_q)) == $past(flags1_q))
	else $error("write with read strobe cleared group1");

	// Interrupt level follows enabled flags
	a_irq_sets: // [RQ16]
	assert property ((flags0_q & en0_q) != 8'h00 || (flags1_q & en1_q) != 8'h00
		|=> IRQ)
	else $error("interrupt missing");

	a_irq_clears: // [RQ16]
	assert property ((flags0_q & en0_q) == 8'h00 && (flags1_q & en1_q) == 8'h00
		|=> !IRQ)
	else $error("interrupt stuck");

endmodule

`default_nettype wire

// ---- verilog/eis_pkg.sv ----
package eis_pkg;

	// Register offsets on the host port
	localparam logic [7:0] EIS_OFS_STATUS0      = 8'h63;
	localparam logic [7:0] EIS_OFS_ENABLE0      = 8'h64;
	localparam logic [7:0] EIS_OFS_PEEK0        = 8'h76;
	localparam logic [7:0] EIS_OFS_ENABLE1      = 8'h7D;
	localparam logic [7:0] EIS_OFS_PEEK1        = 8'h7E;
	localparam logic [7:0] EIS_OFS_STATUS1      = 8'h7F;

	// Reset values
	localparam logic [7:0] EIS_RST_ENABLE0      = 8'h00;
	localparam logic [7:0] EIS_RST_ENABLE1      = 8'h00;
	localparam logic [7:0] EIS_RST_STATUS       = 8'h00;
	localparam logic [7:0] EIS_RDATA_UNMAPPED   = 8'h00;

	// Second-group field positions
	localparam int         EIS_BIT_WAKE         = 5;
	localparam int         EIS_BIT_LINK         = 4;
	localparam int         EIS_BIT_JABBER       = 3;
	localparam int         EIS_BIT_AN_FAIL      = 2;
	localparam int         EIS_BIT_AN_DONE      = 0;

	// Bits of the second group that hold state
	localparam logic [7:0] EIS_GRP1_MASK        = 8'h3D;

	// Cycles from a read strobe to its data
	localparam int         EIS_RD_LATENCY       = 1;

	typedef enum logic [1:0]
	{
		EIS_ACC_NONE,
		EIS_ACC_READ,
		EIS_ACC_WRITE
	} eis_acc_type;

endpackage
